// ===== ebzt_ext_bus.sv
`timescale 1ns/100ps
// Summary of operation
// - No illegal-setting detection logic
// - Four timing/external clock ratio configurations
// - Phases counted, strobes changed on timing ticks
// - Equal clocks: strobes on external rising edge
// - Half clock: parity picks edge
// - Access start aligns to external rising edge
// - Strobe fall edge follows lead parity
// - Strobe rise follows lead plus active parity
// - Access end follows total parity
// - Lead starts on external rising edge
// - Alignment cycle keeps controls inactive
// - Address bus holds last address
// - Upper write strobe is address bit in 16-bit
// - Ready disabled: ignore ready, no waits
// - Lead, active plus one plus waits, trail; doubler
// - Wait states from ready only
// - Ready select: zero sync, one async
module ebzt_ext_bus
    import ebzt_pkg::*;
#(
    parameter int ADDR_W = 20,
    parameter int DATA_W = 32
)(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic external_clock_out,
    output logic zone_select_n,
    output logic read_strobe_n,
    output logic write_strobe_low_n,
    output logic write_strobe_high_n,
    output logic read_not_write,
    output logic [ADDR_W-1:0] ext_addr_bus,
    output logic [DATA_W-1:0] ext_data_out,
    output logic ext_data_oe,
    input wire logic [DATA_W-1:0] ext_data_in,
    input wire logic ext_ready_in
);
    logic [EBZT_TIMING_W-1:0] timing_q;
    logic [EBZT_CTRL_W-1:0] ctrl_q;
    logic [ADDR_W-1:0] req_addr_q;
    logic [DATA_W-1:0] req_wdata_q;
    logic [DATA_W-1:0] rdata_q;
    logic req_read_q, pend_q, dir_read_q;
    logic wr_pend_q, rd_addr_ok;
    logic [7:0] wr_off_q;
    logic [31:0] rd_mux;
    logic [2:0] div_q;
    logic [2:0] div_nxt, mask_t, mask_e;
    logic tick_tim, ext_rise, ext_lvl_d;
    logic tim_half, ext_half, bus32, dbl, rdy_en, rdy_sel;
    logic rdy_m_q, rdy_s_q, rdy_a_q, rdy_ok, wait_now;
    logic [DATA_W-1:0] din_m_q, din_s_q;
    ebzt_state_t state_q, state_d;
    logic [EBZT_CYC_W-1:0] cyc_q, cyc_d;
    logic [EBZT_CYC_W-1:0] lead_len, act_len, trail_len;
    logic [3:0] f_lead, f_act;
    logic [1:0] f_trail;
    logic busy;

    assign tim_half = ctrl_q[EBZT_TIM_HALF_BIT];
    assign ext_half = ctrl_q[EBZT_EXT_HALF_BIT];
    assign bus32 = ctrl_q[EBZT_BUS32_BIT];
    assign dbl = timing_q[EBZT_DOUBLER_BIT];
    assign rdy_en = timing_q[EBZT_RDY_EN_BIT];
    assign rdy_sel = timing_q[EBZT_RDY_SEL_BIT];
    assign busy = pend_q || (state_q != EBZT_IDLE);

    // Zero-wait slave; every access answers OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Address phase capture, writes land in the data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            wr_off_q <= 8'h00;
        end
        else
        begin
            wr_pend_q <= hsel && htrans[1] && hready && hwrite;
            wr_off_q <= haddr[7:0];
        end
    end

    // Read data registered in the address phase, so it stands in the data phase
    assign rd_addr_ok = hsel && htrans[1] && hready && !hwrite;
    always_comb
    begin
        case (haddr[7:0])
            EBZT_OFF_TIMING: rd_mux = {9'h000, timing_q};
            EBZT_OFF_CTRL: rd_mux = {29'h00000000, ctrl_q};
            EBZT_OFF_ADDR: rd_mux = {12'h000, req_addr_q};
            EBZT_OFF_WDATA: rd_mux = req_wdata_q;
            EBZT_OFF_CMD: rd_mux = {31'h00000000, req_read_q};
            EBZT_OFF_STATUS: rd_mux = {30'h00000000, pend_q, busy};
            EBZT_OFF_RDATA: rd_mux = rdata_q;
            default: rd_mux = 32'h00000000;
        endcase
    end
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h00000000;
        else if (rd_addr_ok)
            hrdata <= rd_mux;
    end

    // Software registers; settings are not checked for legality
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            timing_q <= EBZT_TIMING_RST;
            ctrl_q <= EBZT_CTRL_RST;
            req_addr_q <= '0;
            req_wdata_q <= '0;
            req_read_q <= 1'b0;
        end
        else if (wr_pend_q)
        begin
            case (wr_off_q)
                EBZT_OFF_TIMING: timing_q <= hwdata[EBZT_TIMING_W-1:0];
                EBZT_OFF_CTRL: ctrl_q <= hwdata[EBZT_CTRL_W-1:0];
                EBZT_OFF_ADDR: req_addr_q <= hwdata[ADDR_W-1:0];
                EBZT_OFF_WDATA: req_wdata_q <= hwdata[DATA_W-1:0];
                EBZT_OFF_CMD:
                    if (!busy)
                        req_read_q <= hwdata[EBZT_CMD_READ_BIT];
                default: ;
            endcase
        end
    end

    // Command pending flag; a command while busy is dropped
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            pend_q <= 1'b0;
        else if (wr_pend_q && wr_off_q == EBZT_OFF_CMD && !busy)
            pend_q <= 1'b1;
        else if (tick_tim && state_q == EBZT_IDLE)
            pend_q <= 1'b0;
    end

    // System clock is hclk/2; timing clock and external clock divide further only when the half bits are set
    assign div_nxt = div_q + 3'h1;
    assign mask_t = tim_half ? 3'h3 : 3'h1;
    assign mask_e = ext_half ? {mask_t[1:0], 1'b1} : mask_t;
    assign tick_tim = (div_q & mask_t) == mask_t;
    assign ext_rise = (div_q & mask_e) == mask_e;
    assign ext_lvl_d = (div_nxt & mask_e) < ((mask_e >> 1) + 3'h1);
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            div_q <= 3'h0;
            external_clock_out <= 1'b1;
        end
        else
        begin
            div_q <= div_nxt;
            external_clock_out <= ext_lvl_d;
        end
    end

    // Pin inputs pass two flops; async mode adds a third on ready only, for settling
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rdy_m_q <= 1'b0;
            rdy_s_q <= 1'b0;
            rdy_a_q <= 1'b0;
            din_m_q <= '0;
            din_s_q <= '0;
        end
        else
        begin
            rdy_m_q <= ext_ready_in;
            rdy_s_q <= rdy_m_q;
            rdy_a_q <= rdy_s_q;
            din_m_q <= ext_data_in;
            din_s_q <= din_m_q;
        end
    end
    assign rdy_ok = rdy_sel ? rdy_a_q : rdy_s_q;
    assign wait_now = rdy_en && !rdy_ok;

    // Phase lengths in timing ticks, doubled counts when asked
    assign f_lead = dir_read_q ? timing_q[EBZT_RD_LEAD_LSB +: 4] : timing_q[EBZT_WR_LEAD_LSB +: 4];
    assign f_act = dir_read_q ? timing_q[EBZT_RD_ACT_LSB +: 4] : timing_q[EBZT_WR_ACT_LSB +: 4];
    assign f_trail = dir_read_q ? timing_q[EBZT_RD_TRAIL_LSB +: 2]
                                : timing_q[EBZT_WR_TRAIL_LSB +: 2];
    assign lead_len = EBZT_CYC_W'({2'b00, f_lead} << dbl);
    assign act_len = EBZT_CYC_W'({2'b00, f_act} << dbl); // one extra tick via cyc
    assign trail_len = EBZT_CYC_W'({4'h0, f_trail} << dbl);

    // Sequencer steps only on timing ticks parity of edges follows
    always_comb
    begin
        state_d = state_q;
        cyc_d = cyc_q;
        if (tick_tim)
        begin
            case (state_q)
                EBZT_IDLE, EBZT_ALIGN:
                    if (state_q == EBZT_ALIGN || pend_q)
                    begin
                        if (!ext_rise)
                            state_d = EBZT_ALIGN;
                        else if (lead_len != '0)
                        begin
                            state_d = EBZT_LEAD;
                            cyc_d = lead_len - 1'b1;
                        end
                        else
                        begin
                            state_d = EBZT_ACTIVE;
                            cyc_d = act_len;
                        end
                    end
                EBZT_LEAD:
                    if (cyc_q == '0)
                    begin
                        state_d = EBZT_ACTIVE;
                        cyc_d = act_len;
                    end
                    else
                        cyc_d = cyc_q - 1'b1;
                EBZT_ACTIVE:
                    if (cyc_q != '0)
                        cyc_d = cyc_q - 1'b1;
                    else if (wait_now)
                        state_d = EBZT_ACTIVE;
                    else if (trail_len != '0)
                    begin
                        state_d = EBZT_TRAIL;
                        cyc_d = trail_len - 1'b1;
                    end
                    else
                        state_d = EBZT_IDLE;
                EBZT_TRAIL:
                    if (cyc_q == '0)
                        state_d = EBZT_IDLE;
                    else
                        cyc_d = cyc_q - 1'b1;
                default: state_d = EBZT_IDLE;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_q <= EBZT_IDLE;
            cyc_q <= '0;
        end
        else
        begin
            state_q <= state_d;
            cyc_q <= cyc_d;
        end
    end

    // Direction latched with the command, so it is settled before the first tick
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            dir_read_q <= 1'b1;
        else if (wr_pend_q && wr_off_q == EBZT_OFF_CMD && !busy)
            dir_read_q <= hwdata[EBZT_CMD_READ_BIT];
    end

    // Pins registered from next state, so all move on the same hclk edge
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            zone_select_n <= 1'b1;
            read_strobe_n <= 1'b1;
            write_strobe_low_n <= 1'b1;
            write_strobe_high_n <= 1'b1;
            read_not_write <= 1'b1;
            ext_addr_bus <= '0;
            ext_data_out <= '0;
            ext_data_oe <= 1'b0;
        end
        else
        begin
            // Alignment and idle drive all controls inactive
            zone_select_n <= state_d == EBZT_IDLE || state_d == EBZT_ALIGN;
            read_not_write <= !(state_d inside {EBZT_LEAD, EBZT_ACTIVE, EBZT_TRAIL})
                              || dir_read_q;
            read_strobe_n <= !(state_d == EBZT_ACTIVE && dir_read_q);
            write_strobe_low_n <= !(state_d == EBZT_ACTIVE && !dir_read_q);
            // Upper strobe pin doubles as address bit zero on a narrow bus
            if (bus32)
                write_strobe_high_n <= !(state_d == EBZT_ACTIVE && !dir_read_q);
            else if (tick_tim && (state_q == EBZT_IDLE || state_q == EBZT_ALIGN)
                     && state_d != EBZT_ALIGN && state_d != EBZT_IDLE)
                write_strobe_high_n <= req_addr_q[0];
            // Address only moves when a new access starts, else it holds
            if (tick_tim && (state_q == EBZT_IDLE || state_q == EBZT_ALIGN)
                && state_d != EBZT_ALIGN && state_d != EBZT_IDLE)
            begin
                ext_addr_bus <= req_addr_q;
                ext_data_out <= req_wdata_q;
            end
            ext_data_oe <= !dir_read_q && state_d inside {EBZT_ACTIVE, EBZT_TRAIL};
        end
    end

    // Read data taken when the active period closes; pins lag two hclk by sync
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            rdata_q <= '0;
        else if (tick_tim && state_q == EBZT_ACTIVE && state_d != EBZT_ACTIVE && dir_read_q)
            rdata_q <= din_s_q;
    end

    AST_START_RISE: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(zone_select_n) |-> $rose(external_clock_out))
        else $error("access start off the external rising edge");
    AST_ALIGN_QUIET: assert property (@(posedge hclk) disable iff (!hresetn)
        state_q == EBZT_ALIGN |-> zone_select_n && read_strobe_n && write_strobe_low_n)
        else $error("control active during alignment");
    AST_ADDR_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
        zone_select_n && $past(zone_select_n) |-> $stable(ext_addr_bus))
        else $error("address moved between accesses");
    AST_NO_WAIT: assert property (@(posedge hclk) disable iff (!hresetn)
        state_q == EBZT_ACTIVE && cyc_q == '0 && tick_tim && !rdy_en
        |=> state_q != EBZT_ACTIVE)
        else $error("wait inserted with ready disabled");
    AST_READY_WAIT: assert property (@(posedge hclk) disable iff (!hresetn)
        state_q == EBZT_ACTIVE && cyc_q == '0 && tick_tim && rdy_en && !rdy_ok
        |=> state_q == EBZT_ACTIVE)
        else $error("active ended while ready low");
    AST_TICK_ONLY: assert property (@(posedge hclk) disable iff (!hresetn)
        $changed(read_strobe_n) || $changed(zone_select_n) |-> $past(tick_tim))
        else $error("strobe moved off a timing tick");
    AST_FULL_RATE: assert property (@(posedge hclk) disable iff (!hresetn)
        !tim_half && !ext_half && $past(hresetn) && $past(ctrl_q, 2) == ctrl_q
        |-> external_clock_out != $past(external_clock_out))
        else $error("external clock not at timing rate");
    AST_NARROW_A0: assert property (@(posedge hclk) disable iff (!hresetn)
        !bus32 && $stable(bus32) && !zone_select_n |-> write_strobe_high_n == ext_addr_bus[0])
        else $error("upper strobe pin not address bit zero");
    AST_RNW_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
        !write_strobe_low_n |-> !read_not_write && !zone_select_n)
        else $error("write strobe without write direction");
    AST_LEAD_PARITY: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(read_strobe_n) && ext_half && !lead_len[0] |-> $rose(external_clock_out))
        else $error("even lead strobe off rising edge");
endmodule

// ===== ebzt_pkg.sv
package ebzt_pkg;
    // Register byte offsets
    localparam logic [7:0] EBZT_OFF_TIMING = 8'h00;
    localparam logic [7:0] EBZT_OFF_CTRL = 8'h04;
    localparam logic [7:0] EBZT_OFF_ADDR = 8'h08;
    localparam logic [7:0] EBZT_OFF_WDATA = 8'h0C;
    localparam logic [7:0] EBZT_OFF_CMD = 8'h10;
    localparam logic [7:0] EBZT_OFF_STATUS = 8'h14;
    localparam logic [7:0] EBZT_OFF_RDATA = 8'h18;
    // Timing register field positions
    localparam int EBZT_RD_LEAD_LSB = 0;
    localparam int EBZT_RD_ACT_LSB = 4;
    localparam int EBZT_RD_TRAIL_LSB = 8;
    localparam int EBZT_WR_LEAD_LSB = 10;
    localparam int EBZT_WR_ACT_LSB = 14;
    localparam int EBZT_WR_TRAIL_LSB = 18;
    localparam int EBZT_DOUBLER_BIT = 20;
    localparam int EBZT_RDY_EN_BIT = 21;
    localparam int EBZT_RDY_SEL_BIT = 22;
    localparam int EBZT_TIMING_W = 23;
    // Control register field positions
    localparam int EBZT_TIM_HALF_BIT = 0;
    localparam int EBZT_EXT_HALF_BIT = 1;
    localparam int EBZT_BUS32_BIT = 2;
    localparam int EBZT_CTRL_W = 3;
    // Command and status bits
    localparam int EBZT_CMD_READ_BIT = 0;
    localparam int EBZT_ST_BUSY_BIT = 0;
    localparam int EBZT_ST_PEND_BIT = 1;
    // Reset values: all phase counts at maximum with doubler off, 32-bit bus
    localparam logic [22:0] EBZT_TIMING_RST = 23'h0FFFFF;
    localparam logic [2:0] EBZT_CTRL_RST = 3'h4;
    // Phase counter width
    localparam int EBZT_CYC_W = 6;
    typedef enum logic [2:0] {
        EBZT_IDLE,
        EBZT_ALIGN,
        EBZT_LEAD,
        EBZT_ACTIVE,
        EBZT_TRAIL
    } ebzt_state_t;
endpackage

// ===== ebzt_mem_model.sv
`timescale 1ns/100ps
// Behavioural external memory with a slow-ready option
module ebzt_mem_model #(
    parameter int ADDR_W = 20,
    parameter int DATA_W = 32
)(
    input wire logic hclk,
    input wire logic zone_select_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_low_n,
    input wire logic [ADDR_W-1:0] ext_addr_bus,
    input wire logic [DATA_W-1:0] ext_data_out,
    input wire logic ext_data_oe,
    input wire logic [7:0] wait_cycles,
    output logic [DATA_W-1:0] ext_data_in,
    output logic ext_ready_in
);
    logic [DATA_W-1:0] mem_q [16];
    logic strobe_idle;
    int wcnt = 0;
    initial ext_data_in = '0;
    assign strobe_idle = read_strobe_n & write_strobe_low_n;
    // Keeps the last word seen while the write strobe is low
    always @(posedge hclk)
    begin
        if (!zone_select_n && !write_strobe_low_n && ext_data_oe)
            mem_q[ext_addr_bus[3:0]] <= ext_data_out;
    end
    // Released bus toggles, so stale data can never pass for a read
    always @(posedge hclk)
    begin
        if (!zone_select_n && !read_strobe_n)
            ext_data_in <= mem_q[ext_addr_bus[3:0]];
        else
            ext_data_in <= ~ext_data_in;
    end
    // Ready held low for a set number of clocks after a strobe falls
    always @(posedge hclk)
    begin
        if (strobe_idle)
            wcnt <= 0;
        else
            wcnt <= wcnt + 1;
    end
    assign ext_ready_in = strobe_idle || (wcnt >= int'(wait_cycles));
endmodule

// ===== ebzt_ext_bus_tb.sv
`timescale 1ns/100ps
module ebzt_ext_bus_tb;
    import ebzt_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, ext_data_out, ext_data_in;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic hreadyout, hresp, external_clock_out, zone_select_n, read_strobe_n;
    logic write_strobe_low_n, write_strobe_high_n, read_not_write, ext_data_oe, ext_ready_in;
    logic [19:0] ext_addr_bus, a_p = 20'h0, cur_a = 20'h0;
    logic [7:0] wait_cycles = 8'h0;
    logic eh = 1'b0, is_wr = 1'b0, bus32 = 1'b1, zs_p = 1'b1, st_p = 1'b1, ec_p = 1'b1, st;
    int err_total = 0, checks = 0, tmo = 0, cyc = 0, t_lo, t_hi, t_end, tk = 2;
    // Cases: all four clock ratios appear
    int c_ctl [8] = '{4, 6, 5, 7, 2, 6, 6, 6};
    // Lead and active counts of at least one, trail zero with ready
    int c_l [8] = '{1, 1, 2, 3, 1, 1, 1, 1};
    // Async case uses lead 1 with active 2
    int c_a [8] = '{1, 2, 1, 1, 1, 1, 1, 2};
    int c_t [8] = '{1, 1, 0, 2, 1, 0, 0, 0};
    int c_d [8] = '{0, 0, 0, 1, 0, 0, 0, 0};
    int c_en [8] = '{0, 0, 0, 0, 0, 0, 1, 1};
    int c_sel [8] = '{0, 0, 0, 0, 0, 0, 0, 1};
    int c_w [8] = '{0, 0, 0, 0, 0, 20, 20, 20};

    always #2 hclk = ~hclk;

    ebzt_ext_bus u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .external_clock_out(external_clock_out), .zone_select_n(zone_select_n),
        .read_strobe_n(read_strobe_n), .write_strobe_low_n(write_strobe_low_n),
        .write_strobe_high_n(write_strobe_high_n), .read_not_write(read_not_write),
        .ext_addr_bus(ext_addr_bus), .ext_data_out(ext_data_out), .ext_data_oe(ext_data_oe),
        .ext_data_in(ext_data_in), .ext_ready_in(ext_ready_in));

    ebzt_mem_model u_mem (.hclk(hclk), .zone_select_n(zone_select_n),
        .read_strobe_n(read_strobe_n), .write_strobe_low_n(write_strobe_low_n),
        .ext_addr_bus(ext_addr_bus), .ext_data_out(ext_data_out), .ext_data_oe(ext_data_oe),
        .wait_cycles(wait_cycles), .ext_data_in(ext_data_in), .ext_ready_in(ext_ready_in));

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // One single-word transfer; waits on hready, read data taken at the data edge
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(1'b1, a, d, x);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        ahb(1'b0, a, 32'h0, d);
    endtask

    // Strobe edge must land on a tick and on the expected external clock edge
    function automatic logic edge_ok(input int c);
        return (c % tk == 0) && (ec_p !== external_clock_out)
            && (external_clock_out === (!eh || ((c / tk) % 2 == 0)));
    endfunction

    // Phase lengths and alignment, measured in clocks from select falling
    always @(posedge hclk)
    begin
        st = read_strobe_n & write_strobe_low_n;
        if (hresetn)
        begin
            cyc++;
            if (zs_p === 1'b1 && zone_select_n === 1'b0)
            begin
                cyc = 0;
                chk("start_edge", 32'h1, {31'h0, edge_ok(0)});
                chk("rnw", {31'h0, !is_wr}, {31'h0, read_not_write});
            end
            if (st_p === 1'b1 && st === 1'b0)
            begin
                t_lo = cyc;
                chk("fall_edge", 32'h1, {31'h0, edge_ok(cyc)});
                if (is_wr)
                    chk("upper_we", {31'h0, !bus32 & cur_a[0]}, {31'h0, write_strobe_high_n});
            end
            if (st_p === 1'b0 && st === 1'b1)
            begin
                t_hi = cyc;
                chk("rise_edge", 32'h1, {31'h0, edge_ok(cyc)});
            end
            if (zs_p === 1'b0 && zone_select_n === 1'b1)
            begin
                t_end = cyc;
                chk("end_edge", 32'h1, {31'h0, edge_ok(cyc)});
            end
            if (zone_select_n === 1'b1 && zs_p === 1'b1)
            begin
                chk("idle_ctrl", 32'h7, {29'h0, read_strobe_n, write_strobe_low_n, read_not_write});
                chk("addr_hold", {12'h0, a_p}, {12'h0, ext_addr_bus});
            end
        end
        zs_p = zone_select_n;
        st_p = st;
        ec_p = external_clock_out;
        a_p = ext_addr_bus;
    end

    // Hang guard, well above the few hundred clocks the cases need
    always @(posedge hclk)
    begin
        tmo++;
        if (tmo == 20000)
        begin
            err_total++;
            $display("Error timeout expected done seen hang");
            end_sim();
        end
    end

    // One write then one read back with the case's zone timing
    task automatic run(input int i);
        logic [31:0] r, tw, wd;
        int l, a, t, m;
        l = c_l[i];
        a = c_a[i];
        t = c_t[i];
        m = 1 + c_d[i];
        tw = (l << EBZT_RD_LEAD_LSB) | (a << EBZT_RD_ACT_LSB) | (t << EBZT_RD_TRAIL_LSB)
           | (l << EBZT_WR_LEAD_LSB) | (a << EBZT_WR_ACT_LSB) | (t << EBZT_WR_TRAIL_LSB)
           | (c_d[i] << EBZT_DOUBLER_BIT) | (c_en[i] << EBZT_RDY_EN_BIT)
           | (c_sel[i] << EBZT_RDY_SEL_BIT);
        tk = c_ctl[i][0] ? 4 : 2;
        eh = c_ctl[i][1];
        bus32 = c_ctl[i][2];
        cur_a = 20'(i * 3 + 1);
        wd = 32'hC3A50000 + 32'(i);
        wait_cycles <= 8'(c_w[i]);
        wr(EBZT_OFF_CTRL, 32'(c_ctl[i]));
        wr(EBZT_OFF_TIMING, tw);
        rd(EBZT_OFF_TIMING, r);
        chk("timing_rb", tw, r);
        wr(EBZT_OFF_ADDR, {12'h0, cur_a});
        wr(EBZT_OFF_WDATA, wd);
        for (int k = 0; k < 2; k++)
        begin
            is_wr = (k == 0);
            t_lo = -1;
            wr(EBZT_OFF_CMD, 32'(k));
            do rd(EBZT_OFF_STATUS, r); while (r[1:0] !== 2'h0);
            chk("lead", 32'(l * m * tk), 32'(t_lo));
            if (c_en[i] == 0)
                chk("active", 32'((a * m + 1) * tk), 32'(t_hi - t_lo));
            else
                chk("ready_wait", 32'h1, {31'h0, (t_hi - t_lo) > (a * m + 1) * tk && t_hi >= c_w[i] && (t_hi - t_lo) % tk == 0});
            chk("trail", 32'(t * m * tk), 32'(t_end - t_hi));
            chk("addr_last", {12'h0, cur_a}, {12'h0, ext_addr_bus});
        end
        rd(EBZT_OFF_RDATA, r);
        chk("rdata", bus32 ? wd : wd & 32'hFFFF, bus32 ? r : r & 32'hFFFF);
        $display("case %0d done", i);
    endtask

    initial
    begin
        logic [31:0] r;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(EBZT_OFF_TIMING, r);
        chk("timing_rst", {9'h0, EBZT_TIMING_RST}, r);
        rd(EBZT_OFF_CTRL, r);
        chk("ctrl_rst", {29'h0, EBZT_CTRL_RST}, r);
        wr(8'h1C, 32'hFFFFFFFF);
        rd(8'h1C, r);
        chk("unmapped", 32'h0, r);
        $display("register test done");
        for (int i = 0; i < 8; i++)
            run(i);
        end_sim();
    end
endmodule
